/* File: include/mts_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef MTS_DEFS_SVH
`define MTS_DEFS_SVH

`define MTS_OFS_CTRL  8'h00
`define MTS_OFS_TIMES 8'h04
`define MTS_OFS_SPACE 8'h08
`define MTS_OFS_MOTOR 8'h0C
`define MTS_OFS_THERM 8'h10
`define MTS_OFS_DELAY 8'h14
`define MTS_OFS_CMD   8'h18
`define MTS_OFS_STAT  8'h1C
`define MTS_OFS_OCNT  8'h20
`define MTS_OFS_TTIME 8'h24

`define MTS_LO   15:0
`define MTS_HI   31:16
`define MTS_B0   7:0
`define MTS_B1   15:8
`define MTS_B2   23:16
`define MTS_B3   31:24
`define MTS_SRC  3:2
`define MTS_COOL 11:8

`define MTS_CTRL_LAE 0
`define MTS_CTRL_ZSC 1
`define MTS_CTRL_TRE 4
`define MTS_CTRL_ALE 5
`define MTS_CMD_OVR  0

`define MTS_CTRL_RST  32'h0000_0830
`define MTS_TIMES_RST 32'h000A_0014
`define MTS_SPACE_RST 32'h0000_0E10
`define MTS_MOTOR_RST 32'h000F_0600
`define MTS_THERM_RST 32'h105A_6430
`define MTS_DELAY_RST 32'h0000_0000

`define MTS_CLK_MHZ    20
`define MTS_SAMPLE_US  1000
`define MTS_SAMPLE_CYC (`MTS_SAMPLE_US * `MTS_CLK_MHZ)
`define MTS_SPS        (1000000 / `MTS_SAMPLE_US)
`define MTS_HOUR_S     3600
`define MTS_INIT_C     40
`define MTS_TEMP_DIV   240
`define MTS_SS_PCT     50
`define MTS_FULL_PCT   100

`endif

/* File: include/mts_pkg.sv */
// types shared by the motor thermal supervisor
package mts_pkg;
	typedef enum logic [1:0] {
		MTS_SRC_OFF   = 2'h0,
		MTS_SRC_DI    = 2'h1,
		MTS_SRC_PANEL = 2'h2,
		MTS_SRC_ANY   = 2'h3
	} mts_src_t;
	typedef enum logic [1:0] {
		MTS_ACC_IDLE = 2'h0,
		MTS_ACC_HOLD = 2'h1,
		MTS_ACC_DONE = 2'h2
	} mts_acc_t;
endpackage : mts_pkg

/* File: rtl/mts_supervisor.sv */
// motor start supervision and thermal model with apb registers
// Function
// RQ1: long acceleration hold-off runs only when enabled, for its interval
// RQ2: during hold-off accumulator clamps at 100% and thermal trip waits
// RQ3: at hold-off expiry trip unless accumulator is below 100%
// RQ4: with zero-speed check, trip if contact still closed after LOCKED_ROTOR_TIME/2
// RQ5: zero-speed contact closed at rest, opens at low shaft speed
// RQ6: spacing under an hour: cold flag after more than an hour stopped
// RQ7: spacing an hour or more: cold once spacing time has elapsed
// RQ8: accepted override forces cold state at once
// RQ9: override source disabled, input, softkey or either; reset disabled
// RQ10: override from input, enabled softkey, or panel reset command; here the input also needs source input or either
// RQ11: override sets accumulator to 40 degree level, restores cold starts
// RQ12: each override bumps a counter and writes a time-stamped event
// RQ13: override clears and restarts all protective state
// RQ14: heating current squared is I1 squared plus weight times I2 squared
// RQ15: above continuous threshold trip time is ILR^2*TLR over Ieff^2
// RQ16: with temperature, capacity is T/240 plus 50*Ieff^2/(ILR^2*TLR)
// RQ17: temperature biases only with winding, trip-enabled, valid reading
// RQ18: capacity settling below trip threshold never trips
// RQ19: trip and alarm compare capacity to enableable threshold, own delay
// RQ20: sensor failure or all channels off falls back to unbiased model
// RQ21: below continuous threshold accumulator decays by cooling setting
// RQ22: fixed point once per sample, accumulator saturates
`timescale 1ns/1ps
`include "mts_defs.svh"
module mts_supervisor import mts_pkg::*; #(
	parameter int SAMPLE_CYC = `MTS_SAMPLE_CYC,
	parameter int SPS        = `MTS_SPS
) (
	input  logic        clk,
	input  logic        reset_n,
	input  logic [7:0]  paddr,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	input  logic [15:0] pos_seq_cur,
	input  logic [15:0] neg_seq_cur,
	input  logic [9:0]  stator_temp,
	input  logic        temp_valid,
	input  logic        temp_winding_cfg,
	input  logic        temp_trip_en,
	input  logic        temp_module_fail,
	input  logic        temp_all_off,
	input  logic        motor_running,
	input  logic        start_detect,
	input  logic        zero_speed_contact,
	input  logic        override_input_function,
	input  logic        override_softkey,
	output logic        thermal_trip,
	output logic        thermal_alarm,
	output logic        accel_trip,
	output logic        zero_speed_trip,
	output logic        cold_seq,
	output logic        long_accel_holdoff,
	output logic        protect_restart,
	output logic        event_log_stb,
	output logic [31:0] event_time,
	output logic [31:0] trip_time,
	output logic [15:0] capacity_used
);
	localparam int AW = 52;

	if (SAMPLE_CYC < 2 || SAMPLE_CYC > 32767 || SPS < 2 || SPS > 1024) begin
		$error("mts_supervisor: time base parameters out of range");
	end

	function automatic logic [23:0] mts_sq(input logic [15:0] x);
		logic [31:0] p;
		p = x * x;
		return p[31:8];
	endfunction : mts_sq

	function automatic logic [AW-1:0] mts_sat(input logic [AW-1:0] a,
		input logic [AW-1:0] b);
		logic [AW:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[AW] ? {AW{1'b1}} : s[AW-1:0];
	endfunction : mts_sat

	// time base: sample tick and second tick
	logic [14:0] div_ff;
	logic [9:0]  sps_ff;
	logic        smp_tick;
	logic        sec_tick;
	assign smp_tick = div_ff == 15'(SAMPLE_CYC - 1);
	assign sec_tick = smp_tick && sps_ff == 10'(SPS - 1);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_ff <= 15'h0;
			sps_ff <= 10'h0;
		end else begin
			div_ff <= smp_tick ? 15'h0 : div_ff + 15'h1;
			if (sec_tick)
				sps_ff <= 10'h0;
			else if (smp_tick)
				sps_ff <= sps_ff + 10'h1;
		end
	end

	// pin synchronisers; stage 0 feeds stage 1 only
	logic [1:0] zs_s_ff, di_s_ff, sk_s_ff;
	logic       di_d_ff, sk_d_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			zs_s_ff <= 2'h3; // reset as closed, motor assumed at rest
			di_s_ff <= 2'h0;
			sk_s_ff <= 2'h0;
			di_d_ff <= 1'b0;
			sk_d_ff <= 1'b0;
		end else begin
			zs_s_ff <= {zs_s_ff[0], zero_speed_contact};
			di_s_ff <= {di_s_ff[0], override_input_function};
			sk_s_ff <= {sk_s_ff[0], override_softkey};
			di_d_ff <= di_s_ff[1];
			sk_d_ff <= sk_s_ff[1];
		end
	end

	// apb register file, zero wait states
	logic [31:0] ctrl_ff, times_ff, space_ff, motor_ff, therm_ff, delay_ff;
	logic [31:0] prdata_ff, rd_mux, stat_w;
	logic [31:0] ttime_ff, uptime_ff;
	logic [15:0] ovr_cnt_ff, cap_ff;
	logic        map_ok, wr, panel_cmd;
	assign wr = psel && penable && pwrite;
	always_comb begin
		rd_mux = 32'h0;
		map_ok = 1'b1;
		if (paddr == `MTS_OFS_CTRL) rd_mux = ctrl_ff;
		else if (paddr == `MTS_OFS_TIMES) rd_mux = times_ff;
		else if (paddr == `MTS_OFS_SPACE) rd_mux = space_ff;
		else if (paddr == `MTS_OFS_MOTOR) rd_mux = motor_ff;
		else if (paddr == `MTS_OFS_THERM) rd_mux = therm_ff;
		else if (paddr == `MTS_OFS_DELAY) rd_mux = delay_ff;
		else if (paddr == `MTS_OFS_CMD) rd_mux = 32'h0;
		else if (paddr == `MTS_OFS_STAT) rd_mux = stat_w;
		else if (paddr == `MTS_OFS_OCNT) rd_mux = {16'h0, ovr_cnt_ff};
		else if (paddr == `MTS_OFS_TTIME) rd_mux = ttime_ff;
		else map_ok = 1'b0;
	end
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !map_ok;
	assign prdata  = prdata_ff;
	assign panel_cmd = wr && paddr == `MTS_OFS_CMD && pwdata[`MTS_CMD_OVR];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			prdata_ff <= 32'h0;
		else if (psel && !penable && !pwrite)
			prdata_ff <= rd_mux;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_ff  <= `MTS_CTRL_RST; // see RQ9
			times_ff <= `MTS_TIMES_RST;
			space_ff <= `MTS_SPACE_RST;
			motor_ff <= `MTS_MOTOR_RST;
			therm_ff <= `MTS_THERM_RST;
			delay_ff <= `MTS_DELAY_RST;
		end else if (wr) begin
			if (paddr == `MTS_OFS_CTRL) ctrl_ff <= pwdata;
			else if (paddr == `MTS_OFS_TIMES) times_ff <= pwdata;
			else if (paddr == `MTS_OFS_SPACE) space_ff <= pwdata;
			else if (paddr == `MTS_OFS_MOTOR) motor_ff <= pwdata;
			else if (paddr == `MTS_OFS_THERM) therm_ff <= pwdata;
			else if (paddr == `MTS_OFS_DELAY) delay_ff <= pwdata;
		end
	end

	// settings
	mts_src_t    src;
	logic [15:0] locked_rotor_time, spacing, ilr, tlr;
	logic [7:0]  trip_thr, alm_thr, k2, kthr;
	logic [3:0]  cool_sh;
	assign src      = mts_src_t'(ctrl_ff[`MTS_SRC]);
	assign cool_sh  = ctrl_ff[`MTS_COOL];
	assign locked_rotor_time      = times_ff[`MTS_HI];
	assign spacing  = space_ff[`MTS_LO];
	assign ilr      = motor_ff[`MTS_LO];
	assign tlr      = motor_ff[`MTS_HI];
	assign k2       = therm_ff[`MTS_B0];
	assign trip_thr = therm_ff[`MTS_B1];
	assign alm_thr  = therm_ff[`MTS_B2];
	assign kthr     = therm_ff[`MTS_B3];

	// override acceptance
	logic di_rise, sk_rise, ovr_go;
	assign di_rise = di_s_ff[1] && !di_d_ff;
	assign sk_rise = sk_s_ff[1] && !sk_d_ff;
	assign ovr_go = panel_cmd // see RQ10
		|| (di_rise && (src == MTS_SRC_DI || src == MTS_SRC_ANY))
		|| (sk_rise && (src == MTS_SRC_PANEL || src == MTS_SRC_ANY));

	// long acceleration hold-off
	mts_acc_t    acc_st_ff;
	logic [15:0] la_cnt_ff;
	logic        hold;
	assign hold = acc_st_ff == MTS_ACC_HOLD;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_st_ff <= MTS_ACC_IDLE;
			la_cnt_ff <= 16'h0;
		end else if (ovr_go) begin
			acc_st_ff <= MTS_ACC_IDLE; // see RQ13
		end else begin
			case (acc_st_ff)
				MTS_ACC_IDLE: begin
					if (start_detect && ctrl_ff[`MTS_CTRL_LAE]) begin
						acc_st_ff <= MTS_ACC_HOLD; // see RQ1
						la_cnt_ff <= times_ff[`MTS_LO];
					end
				end
				MTS_ACC_HOLD: begin
					if (sec_tick) begin
						if (la_cnt_ff <= 16'h1)
							acc_st_ff <= MTS_ACC_DONE;
						else
							la_cnt_ff <= la_cnt_ff - 16'h1;
					end
				end
				default: acc_st_ff <= MTS_ACC_IDLE;
			endcase
		end
	end

	// zero-speed contact supervision; contact high means closed
	logic [15:0] zs_cnt_ff;
	logic        zs_arm_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			zs_arm_ff <= 1'b0;
			zs_cnt_ff <= 16'h0;
		end else if (ovr_go) begin
			zs_arm_ff <= 1'b0;
		end else if (start_detect && ctrl_ff[`MTS_CTRL_ZSC]) begin
			zs_arm_ff <= 1'b1;
			zs_cnt_ff <= locked_rotor_time >> 1; // see RQ4
		end else if (zs_arm_ff) begin
			if (!zs_s_ff[1])
				zs_arm_ff <= 1'b0; // see RQ5
			else if (sec_tick && zs_cnt_ff <= 16'h1)
				zs_arm_ff <= 1'b0;
			else if (sec_tick)
				zs_cnt_ff <= zs_cnt_ff - 16'h1;
		end
	end

	// cold / warm state
	logic [15:0] stop_s_ff;
	logic        cold_ff, cold_hit;
	assign cold_hit = (spacing < 16'(`MTS_HOUR_S))
		? stop_s_ff > 16'(`MTS_HOUR_S) // see RQ6
		: stop_s_ff >= spacing; // see RQ7
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			stop_s_ff <= 16'h0;
		else if (motor_running)
			stop_s_ff <= 16'h0;
		else if (sec_tick && stop_s_ff != 16'hFFFF)
			stop_s_ff <= stop_s_ff + 16'h1;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cold_ff <= 1'b1;
		else if (ovr_go)
			cold_ff <= 1'b1; // see RQ8
		else if (start_detect)
			cold_ff <= 1'b0;
		else if (!motor_running && cold_hit)
			cold_ff <= 1'b1;
	end

	// thermal model arithmetic
	logic [23:0]   i1sq, i2sq, ilr2;
	logic [31:0]   ksum;
	logic [27:0]   ieff2, kthr2;
	logic [15:0]   kk;
	logic [AW-1:0] lim, init40, target, acc_ff, nxt_acc;
	logic [63:0]   pct_w, tt_w;
	logic          over, bias_ok;
	assign i1sq = mts_sq(pos_seq_cur);
	assign i2sq = mts_sq(neg_seq_cur);
	assign ilr2 = mts_sq(ilr);
	// weight is 4.4 fixed point, hence the shift
	assign ksum = {8'h0, i1sq}
		+ {4'h0, 28'((32'(k2) * 32'(i2sq)) >> 4)}; // see RQ14
	assign ieff2 = |ksum[31:28] ? 28'hFFF_FFFF : ksum[27:0];
	assign kk = kthr * kthr;
	assign kthr2 = {12'h0, kk};
	assign over = ieff2 > kthr2;
	assign lim = AW'(ilr2) * AW'(tlr) * AW'(SPS);
	assign init40 = lim / AW'(`MTS_TEMP_DIV / `MTS_INIT_C); // see RQ11
	// steady level as a fraction of full capacity, no percent divide
	assign target = (lim / AW'(`MTS_TEMP_DIV)) * AW'(stator_temp)
		+ AW'(ieff2) * AW'(SPS * `MTS_SS_PCT); // see RQ16
	assign bias_ok = temp_winding_cfg && temp_trip_en && temp_valid // see RQ17
		&& !temp_module_fail && !temp_all_off; // see RQ20

	always_comb begin
		nxt_acc = acc_ff;
		if (bias_ok) begin
			// first-order lag toward the steady level
			if (target > acc_ff)
				nxt_acc = acc_ff + ((target - acc_ff) >> cool_sh);
			else
				nxt_acc = acc_ff - ((acc_ff - target) >> cool_sh);
		end else if (over) begin
			nxt_acc = mts_sat(acc_ff, AW'(ieff2)); // see RQ22
		end else begin
			nxt_acc = acc_ff - (acc_ff >> cool_sh); // see RQ21
		end
		if (hold && nxt_acc > lim)
			nxt_acc = lim; // see RQ2
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			acc_ff <= {AW{1'b0}};
		else if (ovr_go)
			acc_ff <= init40; // see RQ11
		else if (smp_tick)
			acc_ff <= nxt_acc; // see RQ22
	end

	// divider guards keep simulation free of divide-by-zero
	assign pct_w = (lim == {AW{1'b0}}) ? 64'h0
		: (64'(acc_ff) * 64'(`MTS_FULL_PCT)) / 64'(lim);
	assign tt_w = (64'(ilr2) * 64'(tlr))
		/ 64'((ieff2 == 28'h0) ? 28'h1 : ieff2);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cap_ff   <= 16'h0;
			ttime_ff <= 32'hFFFF_FFFF;
		end else if (smp_tick) begin
			cap_ff <= |pct_w[63:16] ? 16'hFFFF : pct_w[15:0];
			if (over) // see RQ15
				ttime_ff <= |tt_w[63:32] ? 32'hFFFF_FFFF : tt_w[31:0];
			else
				ttime_ff <= 32'hFFFF_FFFF;
		end
	end

	// trip and alarm with their own delays, counted in samples
	logic [15:0] trip_cnt_ff, alm_cnt_ff;
	logic        trip_cond, alm_cond, trip_ff, alarm_ff;
	logic        acc_trip_ff, zs_trip_ff;
	assign trip_cond = ctrl_ff[`MTS_CTRL_TRE] && cap_ff >= {8'h0, trip_thr};
	assign alm_cond  = ctrl_ff[`MTS_CTRL_ALE] && cap_ff >= {8'h0, alm_thr};
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trip_cnt_ff <= 16'h0;
			alm_cnt_ff  <= 16'h0;
		end else if (ovr_go) begin
			trip_cnt_ff <= 16'h0;
			alm_cnt_ff  <= 16'h0;
		end else if (smp_tick) begin
			trip_cnt_ff <= !trip_cond ? 16'h0 : trip_cnt_ff
				+ {15'h0, trip_cnt_ff != 16'hFFFF}; // see RQ19
			alm_cnt_ff <= !alm_cond ? 16'h0 : alm_cnt_ff
				+ {15'h0, alm_cnt_ff != 16'hFFFF};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			trip_ff    <= 1'b0;
			alarm_ff   <= 1'b0;
			acc_trip_ff <= 1'b0;
			zs_trip_ff <= 1'b0;
		end else if (ovr_go) begin
			trip_ff    <= 1'b0; // see RQ13
			alarm_ff   <= 1'b0;
			acc_trip_ff <= 1'b0;
			zs_trip_ff <= 1'b0;
		end else begin
			// hold-off masks only the set, a latched trip stays
			if (smp_tick && trip_cond && !hold // see RQ18
				&& trip_cnt_ff >= delay_ff[`MTS_LO])
				trip_ff <= 1'b1; // see RQ2
			if (smp_tick)
				alarm_ff <= alm_cond && alm_cnt_ff >= delay_ff[`MTS_HI];
			if (acc_st_ff == MTS_ACC_DONE && acc_ff >= lim)
				acc_trip_ff <= 1'b1; // see RQ3
			if (zs_arm_ff && zs_s_ff[1] && sec_tick && zs_cnt_ff <= 16'h1)
				zs_trip_ff <= 1'b1; // see RQ4
		end
	end

	// override history and event log
	logic        ev_ff;
	logic [31:0] ev_time_ff;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			uptime_ff  <= 32'h0;
			ovr_cnt_ff <= 16'h0;
			ev_ff      <= 1'b0;
			ev_time_ff <= 32'h0;
		end else begin
			if (sec_tick)
				uptime_ff <= uptime_ff + 32'h1;
			ev_ff <= ovr_go;
			if (ovr_go) begin
				ovr_cnt_ff <= ovr_cnt_ff + 16'h1; // see RQ12
				ev_time_ff <= uptime_ff;
			end
		end
	end

	assign stat_w = {cap_ff, 9'h0, bias_ok, hold, cold_ff,
		zs_trip_ff, acc_trip_ff, alarm_ff, trip_ff};
	assign thermal_trip       = trip_ff;
	assign thermal_alarm      = alarm_ff;
	assign accel_trip         = acc_trip_ff;
	assign zero_speed_trip    = zs_trip_ff;
	assign cold_seq           = cold_ff;
	assign long_accel_holdoff = hold;
	assign protect_restart    = ev_ff;
	assign event_log_stb      = ev_ff;
	assign event_time         = ev_time_ff;
	assign trip_time          = ttime_ff;
	assign capacity_used      = cap_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	hold_clamp_a: assert property (hold && smp_tick && !ovr_go // see RQ2
		|=> acc_ff <= $past(lim)) else $error("accumulator over limit");
	trip_holdoff_a: assert property ($rose(trip_ff) // see RQ2
		|-> !$past(hold)) else $error("thermal trip during hold-off");
	accel_exp_a: assert property (acc_st_ff == MTS_ACC_DONE // see RQ3
		&& acc_ff >= lim && !ovr_go |=> acc_trip_ff)
		else $error("no trip at hold-off expiry");
	hold_en_a: assert property ($rose(hold) // see RQ1
		|-> $past(ctrl_ff[`MTS_CTRL_LAE] && start_detect))
		else $error("hold-off without enable");
	ovr_src_a: assert property (ovr_go && !panel_cmd // see RQ9
		|-> src != MTS_SRC_OFF) else $error("override while disabled");
	ovr_cold_a: assert property (ovr_go // see RQ8
		|=> cold_ff && acc_ff == $past(init40)) // see RQ11
		else $error("override did not restore cold state");
	ovr_log_a: assert property (ovr_go // see RQ12
		|=> ev_ff && ovr_cnt_ff == $past(ovr_cnt_ff) + 16'h1 ##1 !ev_ff
			|| $past(ovr_go)) else $error("override not logged");
	ovr_clear_a: assert property (ovr_go // see RQ13
		|=> !trip_ff && !acc_trip_ff && !zs_trip_ff && !hold)
		else $error("override left protection state");
	zs_trip_a: assert property ($rose(zs_trip_ff) // see RQ4
		|-> $past(zs_arm_ff && zs_s_ff[1])) else $error("bad zero-speed trip");
	trip_cond_a: assert property ($rose(trip_ff) // see RQ19
		|-> $past(trip_cond)) else $error("trip below threshold");

	hold_cov_c: cover property ($rose(hold) ##[1:1000] $fell(hold));
	ovr_cov_c: cover property (ovr_go ##1 event_log_stb);
	zs_cov_c: cover property ($rose(zs_trip_ff));
	trip_cov_c: cover property ($rose(trip_ff));
endmodule : mts_supervisor

/* File: sim/mts_motor_model.sv */
// far-side model: current sensing, zero-speed contact, temperature module
`timescale 1ns/1ps
module mts_motor_model #(
	parameter int OPEN_PCT = 8
) (
	input  logic        clk,
	input  logic        reset_n,
	input  logic [6:0]  speed_pct,
	input  logic [15:0] cur_pos,
	input  logic [15:0] cur_neg,
	input  logic [9:0]  temp_set,
	input  logic        sensor_fail,
	input  logic        chans_off,
	input  logic        winding_set,
	input  logic        trip_set,
	output logic [15:0] pos_seq_cur,
	output logic [15:0] neg_seq_cur,
	output logic [9:0]  stator_temp,
	output logic        temp_valid,
	output logic        temp_winding_cfg,
	output logic        temp_trip_en,
	output logic        temp_module_fail,
	output logic        temp_all_off,
	output logic        zero_speed_contact
);
	// channel trip enable follows the bench
	assign temp_trip_en = trip_set;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			zero_speed_contact <= 1'b1;
			pos_seq_cur        <= 16'h0000;
			neg_seq_cur        <= 16'h0000;
			stator_temp        <= 10'h000;
			temp_valid         <= 1'b0;
			temp_winding_cfg   <= 1'b0;
			temp_module_fail   <= 1'b0;
			temp_all_off       <= 1'b0;
		end else begin
			zero_speed_contact <= (speed_pct < OPEN_PCT);
			pos_seq_cur        <= cur_pos;
			neg_seq_cur        <= cur_neg;
			temp_winding_cfg   <= winding_set;
			temp_module_fail   <= sensor_fail;
			temp_all_off       <= chans_off;
			temp_valid         <= !sensor_fail && !chans_off;
			// a dead link shows the last reading inverted, then restored, on alternate cycles
			stator_temp <= sensor_fail ? ~stator_temp : temp_set;
		end
	end
endmodule : mts_motor_model

/* File: sim/mts_supervisor_tb.sv */
// self-checking bench of the motor thermal supervisor
`timescale 1ns/1ps
`include "mts_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
	miscompares++; \
	$display("wrong value t=%0t got %0h exp %0h", $time, a, b); end end
module mts_supervisor_tb;
	typedef struct { logic [31:0] d; logic [31:0] m; logic e; } mts_exp_t;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, event_time, trip_time, d;
	logic [15:0] pos_seq_cur, neg_seq_cur, capacity_used, cur_pos, cur_neg;
	logic [9:0]  stator_temp, temp_set;
	logic        temp_valid, temp_winding_cfg, temp_trip_en;
	logic        temp_module_fail, temp_all_off, motor_running;
	logic        start_detect, zero_speed_contact;
	logic        override_input_function, override_softkey;
	logic        thermal_trip, thermal_alarm, accel_trip, zero_speed_trip;
	logic        cold_seq, long_accel_holdoff, protect_restart;
	logic        event_log_stb, sensor_fail, chans_off, winding_set;
	logic [6:0]  speed_pct;
	logic        trip_set;
	int          miscompares, tests_run, pulses, n, c, tb_cyc;
	integer      seed;
	mts_exp_t    exp_q[$];
	mts_exp_t    x;

	mts_supervisor #(.SAMPLE_CYC(4), .SPS(4)) dut (.clk, .reset_n, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.pos_seq_cur, .neg_seq_cur, .stator_temp, .temp_valid,
		.temp_winding_cfg, .temp_trip_en, .temp_module_fail, .temp_all_off,
		.motor_running, .start_detect, .zero_speed_contact,
		.override_input_function, .override_softkey, .thermal_trip,
		.thermal_alarm, .accel_trip, .zero_speed_trip, .cold_seq,
		.long_accel_holdoff, .protect_restart, .event_log_stb, .event_time,
		.trip_time, .capacity_used);
	mts_motor_model model (.clk, .reset_n, .speed_pct, .cur_pos, .cur_neg,
		.temp_set, .sensor_fail, .chans_off, .winding_set, .trip_set,
		.pos_seq_cur, .neg_seq_cur, .stator_temp, .temp_valid,
		.temp_winding_cfg,
		.temp_trip_en, .temp_module_fail, .temp_all_off, .zero_speed_contact);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic conclude;
		$display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : conclude

	// one idle cycle after each transfer keeps drivers single per step
	task automatic apb_go(input logic [7:0] a, input logic w,
			input logic [31:0] v);
		int k;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= v;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) miscompares++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb_go

	task automatic apb_rd(input logic [7:0] a, input logic [31:0] v,
			input logic [31:0] m, input logic e);
		mts_exp_t y;
		y.d = v;
		y.m = m;
		y.e = e;
		exp_q.push_back(y);
		apb_go(a, 1'b0, 32'h0000_0000);
	endtask : apb_rd

	task automatic pin_pulse(input int k);
		if (k != 0) override_softkey <= 1'b1;
		else override_input_function <= 1'b1;
		repeat (8) @(posedge clk);
		override_softkey        <= 1'b0;
		override_input_function <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : pin_pulse

	task automatic start;
		start_detect <= 1'b1;
		@(posedge clk);
		start_detect <= 1'b0;
		@(posedge clk);
	endtask : start

	// read results are checked where the access phase completes
	always @(posedge clk) begin
		if (psel && penable && !pwrite && pready) begin
			if (exp_q.size() == 0) miscompares++;
			else begin
				x = exp_q.pop_front();
				`CHK(prdata & x.m, x.d & x.m)
				`CHK(pslverr, x.e)
			end
		end
		// 16 cycles a second at four samples of four cycles
		if (protect_restart === 1'b1) begin
			pulses++;
			`CHK(event_time, (tb_cyc - 1) / 16)
		end
		if (reset_n === 1'b1) tb_cyc++;
		if (protect_restart || event_log_stb)
			`CHK(event_log_stb, protect_restart)
	end

	initial begin
		#1000000;
		miscompares++;
		conclude();
	end

	initial begin
		seed = 32'h956BBD66;
		{reset_n, psel, penable, pwrite, start_detect, motor_running} = '0;
		{override_input_function, override_softkey, sensor_fail} = '0;
		{chans_off, winding_set, speed_pct, temp_set} = '0;
		trip_set = 1'b1;
		{paddr, pwdata, cur_pos, cur_neg} = '0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		apb_rd(`MTS_OFS_CTRL, `MTS_CTRL_RST, '1, 1'b0);
		apb_rd(`MTS_OFS_TIMES, `MTS_TIMES_RST, '1, 1'b0);
		apb_rd(`MTS_OFS_SPACE, `MTS_SPACE_RST, '1, 1'b0);
		apb_rd(`MTS_OFS_MOTOR, `MTS_MOTOR_RST, '1, 1'b0);
		apb_rd(`MTS_OFS_THERM, `MTS_THERM_RST, '1, 1'b0);
		apb_rd(`MTS_OFS_STAT, 32'h0000_0010, '1, 1'b0);
		apb_rd(`MTS_OFS_TTIME, 32'hFFFF_FFFF, '1, 1'b0);
		apb_rd(8'h28, 32'h0000_0000, '1, 1'b1);
		d = $random(seed);
		apb_go(`MTS_OFS_DELAY, 1'b1, d);
		apb_rd(`MTS_OFS_DELAY, d, '1, 1'b0);
		apb_go(`MTS_OFS_DELAY, 1'b1, 32'h0000_0000);
		motor_running <= 1'b1;
		start();
		apb_rd(`MTS_OFS_STAT, 32'h0000_0000, 32'h0000_0010, 1'b0);
		apb_go(`MTS_OFS_CMD, 1'b1, 32'h0000_0001);
		@(posedge clk);
		`CHK(pulses, 1)
		apb_rd(`MTS_OFS_STAT, 32'h0000_0010, 32'h0000_0010, 1'b0);
		for (int s = 0; s < 4; s++) begin
			apb_go(`MTS_OFS_CTRL, 1'b1, 32'h0000_0830 | (s << 2));
			n = pulses;
			pin_pulse(0);
			`CHK(pulses - n, s & 1)
			n = pulses;
			pin_pulse(1);
			`CHK(pulses - n, s >> 1)
		end
		apb_go(`MTS_OFS_OCNT, 1'b1, 32'h0000_0055);
		apb_rd(`MTS_OFS_OCNT, 32'h0000_0005, 32'h0000_FFFF, 1'b0);
		// heavy start under hold-off: bucket fills, trip must wait
		apb_go(`MTS_OFS_CMD, 1'b1, 32'h0000_0001);
		apb_go(`MTS_OFS_CTRL, 1'b1, 32'h0000_0831);
		apb_go(`MTS_OFS_TIMES, 1'b1, 32'h0014_0014);
		cur_pos <= 16'h0600;
		start();
		`CHK(long_accel_holdoff, 1'b1)
		n = 1;
		while (long_accel_holdoff === 1'b1 && n < 400) begin
			`CHK(thermal_trip, 1'b0)
			`CHK(capacity_used <= 16'd100, 1'b1)
			@(posedge clk);
			n++;
		end
		`CHK(n >= 300 && n <= 324, 1'b1)
		cur_pos <= 16'h0000;
		repeat (3) @(posedge clk);
		`CHK(accel_trip, 1'b1)
		`CHK(thermal_alarm, 1'b1)
		apb_go(`MTS_OFS_CTRL, 1'b1, 32'h0000_0811);
		repeat (8) @(posedge clk);
		`CHK(thermal_alarm, 1'b0)
		c = capacity_used;
		repeat (80) @(posedge clk);
		`CHK(capacity_used < c, 1'b1)
		apb_go(`MTS_OFS_CMD, 1'b1, 32'h0000_0001);
		`CHK(accel_trip, 1'b0)
		apb_go(`MTS_OFS_CTRL, 1'b1, 32'h0000_0831);
		apb_go(`MTS_OFS_TIMES, 1'b1, 32'h0014_0002);
		start();
		n = 0;
		while (long_accel_holdoff === 1'b1 && n < 60) begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		`CHK(accel_trip, 1'b0)
		apb_go(`MTS_OFS_CTRL, 1'b1, 32'h0000_0830);
		start();
		`CHK(long_accel_holdoff, 1'b0)
		// stalled rotor: contact stays closed past half locked time
		apb_go(`MTS_OFS_CTRL, 1'b1, 32'h0000_0832);
		apb_go(`MTS_OFS_TIMES, 1'b1, 32'h0004_0002);
		start();
		repeat (8) @(posedge clk);
		`CHK(zero_speed_trip, 1'b0)
		repeat (40) @(posedge clk);
		`CHK(zero_speed_trip, 1'b1)
		apb_go(`MTS_OFS_CMD, 1'b1, 32'h0000_0001);
		`CHK(zero_speed_trip, 1'b0)
		speed_pct <= 7'd50;
		repeat (10) @(posedge clk);
		start();
		repeat (48) @(posedge clk);
		`CHK(zero_speed_trip, 1'b0)
		apb_go(`MTS_OFS_CMD, 1'b1, 32'h0000_0001);
		repeat (6) @(posedge clk);
		`CHK(capacity_used, 16'd16)
		cur_pos <= 16'h0200;
		repeat (16) @(posedge clk);
		`CHK(trip_time, 32'd135)
		cur_pos <= 16'h0100;
		cur_neg <= 16'h0100;
		repeat (16) @(posedge clk);
		`CHK(trip_time, 32'd135)
		cur_pos <= $random(seed) & 16'h00FF;
		cur_neg <= 16'h0000;
		repeat (16) @(posedge clk);
		`CHK(trip_time, 32'hFFFF_FFFF)
		cur_pos <= 16'h0000;
		// bias needs winding channels, trip enable and a valid reading
		temp_set    <= 10'd100;
		winding_set <= 1'b1;
		repeat (12) @(posedge clk);
		apb_rd(`MTS_OFS_STAT, 32'h0000_0040, 32'h0000_0040, 1'b0);
		sensor_fail <= 1'b1;
		repeat (12) @(posedge clk);
		apb_rd(`MTS_OFS_STAT, 32'h0000_0000, 32'h0000_0040, 1'b0);
		sensor_fail <= 1'b0;
		chans_off   <= 1'b1;
		repeat (12) @(posedge clk);
		apb_rd(`MTS_OFS_STAT, 32'h0000_0000, 32'h0000_0040, 1'b0);
		chans_off   <= 1'b0;
		trip_set    <= 1'b0;
		repeat (12) @(posedge clk);
		apb_rd(`MTS_OFS_STAT, 32'h0000_0000, 32'h0000_0040, 1'b0);
		trip_set    <= 1'b1;
		winding_set <= 1'b0;
		repeat (12) @(posedge clk);
		apb_rd(`MTS_OFS_STAT, 32'h0000_0000, 32'h0000_0040, 1'b0);
		repeat (4) @(posedge clk);
		conclude();
	end
endmodule : mts_supervisor_tb
